// File: dv/porc_board_sup.sv
// board reset supervisor model driving the power-on reset input
`timescale 1ns/1ps
`default_nettype none
module porc_board_sup (
   input  wire logic       clk_in,
   input  wire logic       go_in,
   input  wire logic [4:0] extra_in,
   output logic            power_on_reset_n_out
);
   logic [5:0] hold_cnt;

   initial begin
      power_on_reset_n_out = 1'b0;
      hold_cnt             = 6'h00;
   end

   // low from power-up, then each pulse holds low 16 clocks or more
   always @(posedge clk_in) begin
      if (go_in) begin
         hold_cnt             <= 6'h10 + {1'b0, extra_in};
         power_on_reset_n_out <= 1'b0;
      end else if (hold_cnt != 6'h00) begin
         hold_cnt <= hold_cnt - 6'h01;
         if (hold_cnt == 6'h01) begin
            power_on_reset_n_out <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/porc_top_tb.sv
// self-checking bench for the power-on reset sequencer
`timescale 1ns/1ps
`default_nettype none
module porc_top_tb;
   logic        clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        go = 1'b0;
   logic [4:0]  extra = 5'h00;
   logic [4:0]  straps = 5'h00;
   logic        ext_pull = 1'b1;
   logic        hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b010;
   wire logic   por_n, oe_n, hd_out, pll_rst, core_rst, hready, hresp, cfg_v, wdog, narrow, pol;
   wire logic   hard_line;
   wire logic [1:0]  boot;
   wire logic [15:0] cfg_w;
   wire logic [31:0] hrdata;
   int          n_mismatch = 0, comparisons = 0, cyc = 0, t_e, i;
   logic [31:0] s, cfg;

   // open-drain wire with pull-up, wired with the board's own pull-down
   assign hard_line = (oe_n & ext_pull);

   always #2.5 clk_in = ~clk_in;
   always @(posedge clk_in) cyc <= cyc + 1;

   porc_board_sup sup (.clk_in(clk_in), .go_in(go), .extra_in(extra), .power_on_reset_n_out(por_n));

   porc_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .power_on_reset_n_in(por_n),
      .boot_source_select_in(straps[1:0]), .watchdog_enable_strap_in(straps[2]),
      .host_narrow_bus_strap_in(straps[3]), .host_strobe_polarity_strap_in(straps[4]),
      .hard_reset_n_in(hard_line), .hard_reset_n_out(hd_out), .hard_reset_n_oe_n_out(oe_n),
      .pll_dll_reset_out(pll_rst), .core_reset_out(core_rst), .boot_source_select_out(boot),
      .watchdog_enable_out(wdog), .host_narrow_bus_out(narrow), .host_strobe_polarity_out(pol),
      .reset_cfg_word_out(cfg_w), .reset_cfg_valid_out(cfg_v), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
      .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp));

   // compare one value
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask

   // one single AHB-Lite word transfer, entered right after a rising edge
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      logic rdy;
      hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w; hsize <= 3'b010;
      do begin @(negedge clk_in); rdy = hready; @(posedge clk_in); end while (rdy !== 1'b1);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
      do begin @(negedge clk_in); rdy = hready; r = hrdata; @(posedge clk_in); end while (rdy !== 1'b1);
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("hready", 32'h1, {31'h0, hready});
   endtask

   // wait until the hard reset line is let go, bounded
   task automatic wait_release();
      int n;
      n = 0;
      do begin @(negedge clk_in); n++; end while (oe_n !== 1'b1 && n < 2000);
      chk("released", 32'h1, {31'h0, oe_n});
      @(posedge clk_in);
   endtask

   // straps seen at the outputs
   function automatic logic [31:0] strap_word();
      return {27'h0, pol, narrow, wdog, boot};
   endfunction

   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // watchdog against a hung handshake
   initial begin
      #100000;
      n_mismatch++;
      report_and_stop();
   end

   // main sequence
   initial begin
      void'($urandom(32'h740c82db));
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      for (i = 0; i < 4; i++) begin
         s = $urandom;
         if (i == 3) s = 32'hffff_ffff; // all-ones corner, longest hold
         @(posedge clk_in);
         straps <= s[4:0]; extra <= s[9:5]; go <= 1'b1;
         @(posedge clk_in);
         go <= 1'b0;
         repeat (4) @(posedge clk_in);
         @(negedge clk_in);
         chk("pll_rst", 32'h1, {31'h0, pll_rst});
         chk("core_rst", 32'h1, {31'h0, core_rst});
         chk("oe_n", 32'h0, {31'h0, oe_n});
         chk("hd_out", 32'h0, {31'h0, hd_out});
         chk("cfg valid low", 32'h0, {31'h0, cfg_v});
         while (por_n !== 1'b1) @(negedge clk_in);
         @(posedge clk_in);
         straps <= ~s[4:0];
         @(negedge clk_in);
         t_e = cyc;
         @(posedge clk_in);
         cfg = {15'h0, s[10], s[31:16]};
         ahb(1'b1, 32'hc, cfg, rd);
         ahb(1'b0, 32'hc, 32'h0, rd);
         chk("cfg rd", cfg, rd);
         chk("cfg word", cfg & 32'h0000_ffff, {16'h0, cfg_w});
         chk("cfg valid", 32'h1, {31'h0, cfg_v});
         chk("pll_rst", 32'h0, {31'h0, pll_rst});
         chk("straps", {27'h0, s[4:0]}, strap_word());
         wait_release();
         chk("release", 32'd521, cyc - t_e);
         chk("core_rst", 32'h0, {31'h0, core_rst});
         ahb(1'b1, 32'hc, ~cfg, rd);
         ahb(1'b1, 32'h0, ~s, rd);
         ahb(1'b0, 32'hc, 32'h0, rd);
         chk("cfg locked", cfg, rd);
         chk("cfg word kept", cfg & 32'h0000_ffff, {16'h0, cfg_w});
         ahb(1'b0, 32'h0, 32'h0, rd);
         chk("strap rd", {27'h0, s[4:0]}, rd);
         ahb(1'b0, 32'h4, 32'h0, rd);
         chk("status", 32'h12, rd);
         ahb(1'b0, 32'h10 + {s[15:12], 2'b00}, 32'h0, rd);
         chk("unmapped", 32'h0, rd);
         if (i[0]) begin
            ahb(1'b1, 32'h8, 32'h1, rd);
         end else begin
            ext_pull <= 1'b0;
            repeat (3) @(posedge clk_in);
            ext_pull <= 1'b1;
         end
         repeat (3) @(posedge clk_in);
         @(negedge clk_in);
         chk("hard oe_n", 32'h0, {31'h0, oe_n});
         chk("hard core", 32'h1, {31'h0, core_rst});
         wait_release();
         chk("straps kept", {27'h0, s[4:0]}, strap_word());
         ahb(1'b0, 32'h8, 32'h0, rd);
         chk("ctrl rd", 32'h0, rd);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire

// File: rtl/porc_cnt_if.sv
// start and done handshake between the sequencer and its release counter
`timescale 1ns/1ps
`default_nettype none
interface porc_cnt_if;
   logic start;
   logic done;

   modport seq (output start, input done);
   modport cnt (input start, output done);
endinterface
`default_nettype wire

// File: rtl/porc_counter.sv
// release delay counter: done rises COUNT cycles after a start pulse
`timescale 1ns/1ps
`default_nettype none
module porc_counter #(
   parameter int COUNT = 521,
   parameter int W     = 10
)(
   input  wire logic   clk_in,
   input  wire logic   rst_n_in,
   porc_cnt_if.cnt     cnt_if
);

   logic [W-1:0] cnt;
   logic         busy;
   logic [W-1:0] next_cnt;
   logic         next_busy;

   // refuse counts that do not fit the counter
   if (COUNT < 1 || COUNT > (2 ** W)) begin : g_bad_count
      $error("porc_counter: COUNT does not fit W bits");
   end

   assign cnt_if.done = busy && (cnt == '0);

   // load on start, count down, stop at zero
   always_comb begin
      next_cnt  = cnt;
      next_busy = busy;
      if (cnt_if.start) begin
         next_cnt  = W'(COUNT - 1);
         next_busy = 1'b1;
      end else if (busy && cnt != '0) begin
         next_cnt = cnt - W'(1);
      end else if (busy) begin
         next_busy = 1'b0;
      end
   end

   // counter registers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt  <= '0;
         busy <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         busy <= next_busy;
      end
   end

endmodule
`default_nettype wire

// File: rtl/porc_defs.svh
// register map, field positions, reset values and timing counts of the reset sequencer
`ifndef PORC_DEFS_SVH
`define PORC_DEFS_SVH

// register byte offsets
`define PORC_STRAP_OFF        32'h0000_0000
`define PORC_STATUS_OFF       32'h0000_0004
`define PORC_CTRL_OFF         32'h0000_0008
`define PORC_CFG_OFF          32'h0000_000c

// strap register fields
`define PORC_STRAP_BOOT_LSB   0
`define PORC_STRAP_WDOG_BIT   2
`define PORC_STRAP_NARROW_BIT 3
`define PORC_STRAP_POL_BIT    4
`define PORC_STRAP_RST        5'h00

// status register fields
`define PORC_STAT_STATE_LSB   0
`define PORC_STAT_DRIVE_BIT   2
`define PORC_STAT_LINE_BIT    3
`define PORC_STAT_CFGV_BIT    4

// control register fields
`define PORC_CTRL_SWHR_BIT    0

// configuration word register fields
`define PORC_CFG_WORD_W       16
`define PORC_CFG_SRC_BIT      16
`define PORC_CFG_RST          16'h0000

// timing counts, in input reference clock cycles
`define PORC_POR_MIN_CYCLES   16
`define PORC_RELEASE_CYCLES   521

`endif

// File: rtl/porc_pkg.sv
// types shared by the reset sequencer modules
package porc_pkg;

   // sequencer states
   typedef enum logic [1:0] {
      PORC_POR_HOLD,
      PORC_RELEASE_WAIT,
      PORC_RUN,
      PORC_HARD_WAIT
   } porc_state_t;

   // who wrote the reset configuration word
   typedef enum logic {
      PORC_SRC_HOST,
      PORC_SRC_I2C
   } porc_src_t;

endpackage

// File: rtl/porc_top.sv
// power-on reset sequencer with strap capture, open-drain hard reset and AHB-Lite registers
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "porc_defs.svh"
module porc_top
   import porc_pkg::*;
#(
   parameter int CNT_W = 10
)(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // board reset and straps
   input  wire logic        power_on_reset_n_in,
   input  wire logic [1:0]  boot_source_select_in,
   input  wire logic        watchdog_enable_strap_in,
   input  wire logic        host_narrow_bus_strap_in,
   input  wire logic        host_strobe_polarity_strap_in,
   // open-drain hard reset line
   input  wire logic        hard_reset_n_in,
   output logic             hard_reset_n_out,
   output logic             hard_reset_n_oe_n_out,
   // resets and configuration towards the device
   output logic             pll_dll_reset_out,
   output logic             core_reset_out,
   output logic [1:0]       boot_source_select_out,
   output logic             watchdog_enable_out,
   output logic             host_narrow_bus_out,
   output logic             host_strobe_polarity_out,
   output logic [15:0]      reset_cfg_word_out,
   output logic             reset_cfg_valid_out,
   // AHB-Lite slave
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic [31:0]      hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out
);

   porc_cnt_if  cnt_bus ();

   porc_state_t state;
   porc_state_t next_state;
   logic        por_prev;
   logic        por_rise;
   logic        drive;
   logic        next_drive;
   logic        pll_rst;
   logic        next_pll_rst;
   logic        core_rst;
   logic        next_core_rst;
   logic [4:0]  straps;
   logic [4:0]  next_straps;
   logic [15:0] cfg_word;
   logic [15:0] next_cfg_word;
   logic        cfg_src;
   logic        next_cfg_src;
   logic        cfg_valid;
   logic        next_cfg_valid;
   logic        dp_valid;
   logic        dp_write;
   logic [31:0] dp_addr;
   logic [31:0] rdata;
   logic        next_dp_valid;
   logic        next_dp_write;
   logic [31:0] next_dp_addr;
   logic [31:0] next_rdata;
   logic        acc;
   logic        sw_hard_req;
   logic        cfg_write;

   // word-aligned register hit
   function automatic logic hit(input logic [31:0] addr, input logic [31:0] off);
      hit = (addr[31:2] == off[31:2]);
   endfunction

   porc_counter #(
      .COUNT (`PORC_RELEASE_CYCLES),
      .W     (CNT_W)
   ) u_cnt (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .cnt_if   (cnt_bus)
   );

   // open drain: the pin is only ever pulled low
   assign hard_reset_n_out      = 1'b0;
   assign hard_reset_n_oe_n_out = !drive;
   assign pll_dll_reset_out     = pll_rst;
   assign core_reset_out        = core_rst;
   assign por_rise              = power_on_reset_n_in && !por_prev;
   assign {host_strobe_polarity_out, host_narrow_bus_out, watchdog_enable_out, boot_source_select_out} = straps;
   assign reset_cfg_word_out    = cfg_word;
   assign reset_cfg_valid_out   = cfg_valid;

   // AHB-Lite: zero wait states, always OKAY
   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;
   assign hrdata_out    = rdata;
   assign acc           = hsel_in && htrans_in[1] && hready_in && (hsize_in == 3'h2);
   assign sw_hard_req   = dp_valid && dp_write && hit(dp_addr, `PORC_CTRL_OFF)
                          && hwdata_in[`PORC_CTRL_SWHR_BIT];
   // configuration word only taken while the power-on release is counting
   assign cfg_write     = dp_valid && dp_write && hit(dp_addr, `PORC_CFG_OFF)
                          && (state == PORC_RELEASE_WAIT);

   // sequencer next state
   always_comb begin
      next_state    = state;
      cnt_bus.start = 1'b0;
      if (!power_on_reset_n_in) begin
         next_state = PORC_POR_HOLD;
      end else begin
         case (state)
            PORC_POR_HOLD: begin
               if (por_rise) begin
                  next_state    = PORC_RELEASE_WAIT;
                  cnt_bus.start = 1'b1;
               end
            end
            PORC_RELEASE_WAIT: begin
               if (cnt_bus.done) begin
                  next_state = PORC_RUN;
               end
            end
            PORC_RUN: begin
               if (sw_hard_req || !hard_reset_n_in) begin
                  next_state    = PORC_HARD_WAIT;
                  cnt_bus.start = 1'b1;
               end
            end
            PORC_HARD_WAIT: begin
               if (cnt_bus.done) begin
                  next_state = PORC_RUN;
               end
            end
            default: next_state = PORC_POR_HOLD;
         endcase
      end
      next_drive    = (next_state != PORC_RUN);
      next_core_rst = (next_state != PORC_RUN);
      next_pll_rst  = (next_state == PORC_POR_HOLD);
   end

   // sequencer registers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state    <= PORC_POR_HOLD;
         por_prev <= 1'b0;
         drive    <= 1'b1;
         core_rst <= 1'b1;
         pll_rst  <= 1'b1;
      end else begin
         state    <= next_state;
         por_prev <= power_on_reset_n_in;
         drive    <= next_drive;
         core_rst <= next_core_rst;
         pll_rst  <= next_pll_rst;
      end
   end

   // strap capture and configuration word
   always_comb begin
      next_straps    = straps;
      next_cfg_word  = cfg_word;
      next_cfg_src   = cfg_src;
      next_cfg_valid = cfg_valid;
      if (state == PORC_POR_HOLD && por_rise) begin
         next_straps = {host_strobe_polarity_strap_in, host_narrow_bus_strap_in,
                        watchdog_enable_strap_in, boot_source_select_in};
      end
      if (!power_on_reset_n_in) begin
         next_cfg_valid = 1'b0;
      end else if (cfg_write) begin
         next_cfg_word  = hwdata_in[`PORC_CFG_WORD_W-1:0];
         next_cfg_src   = hwdata_in[`PORC_CFG_SRC_BIT];
         next_cfg_valid = 1'b1;
      end
   end

   // configuration registers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         straps    <= `PORC_STRAP_RST;
         cfg_word  <= `PORC_CFG_RST;
         cfg_src   <= 1'b0;
         cfg_valid <= 1'b0;
      end else begin
         straps    <= next_straps;
         cfg_word  <= next_cfg_word;
         cfg_src   <= next_cfg_src;
         cfg_valid <= next_cfg_valid;
      end
   end

   // bus address phase capture and read mux
   always_comb begin
      next_dp_valid = acc;
      next_dp_write = acc && hwrite_in;
      next_dp_addr  = acc ? haddr_in : dp_addr;
      next_rdata    = 32'h0000_0000;
      if (acc && !hwrite_in) begin
         if (hit(haddr_in, `PORC_STRAP_OFF)) begin
            next_rdata[4:0] = straps;
         end else if (hit(haddr_in, `PORC_STATUS_OFF)) begin
            next_rdata[`PORC_STAT_STATE_LSB +: 2] = state;
            next_rdata[`PORC_STAT_DRIVE_BIT]      = drive;
            next_rdata[`PORC_STAT_LINE_BIT]       = !hard_reset_n_in;
            next_rdata[`PORC_STAT_CFGV_BIT]       = cfg_valid;
         end else if (hit(haddr_in, `PORC_CFG_OFF)) begin
            next_rdata[`PORC_CFG_WORD_W-1:0] = cfg_word;
            next_rdata[`PORC_CFG_SRC_BIT]    = cfg_src;
         end
      end
   end

   // bus registers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr  <= 32'h0000_0000;
         rdata    <= 32'h0000_0000;
      end else begin
         dp_valid <= next_dp_valid;
         dp_write <= next_dp_write;
         dp_addr  <= next_dp_addr;
         rdata    <= next_rdata;
      end
   end

   // cycles since the last power-on release, checker helper
   logic [11:0] since_rise;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         since_rise <= 12'hfff;
      end else if (por_rise) begin
         since_rise <= 12'h000;
      end else if (since_rise != 12'hfff) begin
         since_rise <= since_rise + 12'h001;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   por_starts_flow_a: assert property (!power_on_reset_n_in |=> state == PORC_POR_HOLD && drive)
      else $error("power-on reset did not start the flow");
   por_side_resets_a: assert property (!power_on_reset_n_in |=> pll_rst && core_rst && !hard_reset_n_oe_n_out)
      else $error("power-on reset left pll, core or hard reset released");
   strap_capture_a: assert property (state == PORC_POR_HOLD && por_rise |=>
      straps == $past({host_strobe_polarity_strap_in, host_narrow_bus_strap_in,
                       watchdog_enable_strap_in, boot_source_select_in}))
      else $error("straps not captured on power-on release");
   release_time_a: assert property ($rose(hard_reset_n_oe_n_out) && $past(state) == PORC_RELEASE_WAIT
      |-> since_rise == 12'(`PORC_RELEASE_CYCLES))
      else $error("hard reset released at wrong time");
   release_hold_a: assert property (state == PORC_RELEASE_WAIT
      && since_rise < 12'(`PORC_RELEASE_CYCLES - 1) |=> drive)
      else $error("hard reset released early");
   straps_stable_a: assert property (power_on_reset_n_in && $past(power_on_reset_n_in) |=> $stable(straps))
      else $error("straps changed without power-on reset");
   hard_keeps_straps_a: assert property (state == PORC_RUN && sw_hard_req && power_on_reset_n_in
      |=> state == PORC_HARD_WAIT ##1 $stable(straps))
      else $error("hard reset disturbed straps");
   open_drain_a: assert property (drive |-> !hard_reset_n_out && !hard_reset_n_oe_n_out && core_rst)
      else $error("hard reset not pulled low while driven");
   cfg_window_a: assert property (dp_valid && dp_write && hit(dp_addr, `PORC_CFG_OFF)
      && state != PORC_RELEASE_WAIT && power_on_reset_n_in |=> $stable(cfg_word))
      else $error("configuration word taken outside its window");

endmodule
`default_nettype wire
